// File: rfb_pkg.sv
// Constants, carrier structs, states and the state record of the receive frame buffer.
// Assumes a 200 MHz device clock and a 16-bit host data path.
package rfb_pkg;
   localparam logic [11:0] OFS_CHAN = 12'h0024;
   localparam logic [11:0] OFS_SOF = 12'h0026;
   localparam logic [11:0] OFS_FCNT = 12'h0028;
   localparam logic [11:0] OFS_BCNT = 12'h002A;
   localparam logic [11:0] OFS_QUEUE = 12'h0120;
   localparam logic [11:0] OFS_STAT = 12'h0400;
   localparam logic [11:0] OFS_LEN = 12'h0402;
   localparam logic [11:0] OFS_DATA = 12'h0404;
   localparam logic [10:0] MAX_STORE = 11'd1518;
   localparam logic [10:0] FIRST_BLOCK = 11'd128;
   localparam logic [15:0] HDR_BYTES = 16'h0004;
   localparam logic [15:0] ALIGN_ADD = 16'h0007;
   localparam logic [15:0] DWORD_MASK = 16'hFFFC;
   localparam logic [15:0] RING16_MASK = 16'h3FFF;
   localparam logic [15:0] RING64_MASK = 16'hFFFF;
   localparam logic [1:0] CHAN_MAX = 2'd2;
   localparam int RAM_AW = 10;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int CLK_MHZ = 200;
   localparam int BURST_HIGH_NS = 30000;
   localparam int BURST_GAP_NS = 800;
   // Longest time rounds down, least time rounds up
   localparam int BURST_HIGH_CYC = (BURST_HIGH_NS * CLK_MHZ) / 1000;
   localparam int BURST_GAP_CYC = (BURST_GAP_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      BS_EMPTY = 3'b000,
      BS_FILL = 3'b001,
      BS_HELD = 3'b010,
      BS_DMA = 3'b011,
      BS_DRAIN = 3'b100
   } rfb_buf_e;

   typedef struct packed {
      logic sof;
      logic valid;
      logic [7:0] data;
      logic fcs;
      logic da_pass;
      logic eof;
      logic accept;
      logic good;
      logic [15:0] status;
   } rfb_rx_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic io_rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } rfb_host_s;

   typedef struct packed {
      rfb_buf_e st;
      logic [10:0] wr_cnt;
      logic [7:0] lo_byte;
      logic [9:0] rd_ptr;
      logic [1:0] io_phase;
      logic partial;
      logic commit;
      logic [15:0] status;
      logic [15:0] length;
      logic dest_flag;
      logic blk_flag;
      logic [1:0] dma_phase;
      logic [9:0] dptr;
      logic [11:0] frame_cnt;
      logic [15:0] byte_cnt;
      logic [15:0] sof;
      logic [15:0] ring_ptr;
      logic [12:0] burst_cnt;
      logic [7:0] gap_cnt;
      logic in_gap;
      logic [1:0] chan;
      logic [15:0] rdata;
      logic good_evt;
      logic dest_irq;
      logic blk_irq;
   } rfb_state_s;

   typedef struct packed {
      logic [4:0] wptr;
      logic [4:0] rptr;
   } rfb_fifo_s;
endpackage

// File: rfb_frame_buffer.sv
// Receive frame buffer with host readout and receive-only slave DMA, plus its DMA word FIFO.
// Assumes the MAC delivers filtered bytes on rx, and that event-report reads are signalled as pulses.
//
// Operation
// - Good-frame event raised only at end of frame, storing at most 1518 bytes.
// - Complete frame is committed when the host reads the receive event report.
// - Partial frame with an early flag is committed when buffer events are read.
// - No later frame is written while a frame occupies or holds the buffer.
// - Sequential readout of the whole frame releases it.
// - Skip command from the host releases the current frame.
// - Event read revealing another frame after a partial read is an implied skip.
// - Early interrupts are suppressed while a committed frame waits.
// - Data reads at paged 0404h, or I/O port giving status, length, then data.
// - One frame visible; status at 0400h, length at 0402h.
// - With keep-FCS set the four CRC bytes are stored and counted.
// - DMA only ever carries received frames.
// - DMA-exclusive sends every frame by DMA, overriding auto-switch.
// - Channel select at 0024h holds 0, 1 or 2, picking the pin pair.
// - Register 0026h holds offset of latest DMA frame start.
// - Register 0028h counts DMA frames in 12 bits since last read.
// - Register 002Ah counts DMA bytes since last read.
// - Ring-size bit picks 16 or 64 Kbyte ring for the offset logic.
// - Request goes high after an accepted frame; controller acknowledges low.
// - DMA sends status word, then length word, then frame data.
// - Burst limit keeps request high at most 30 us, then low 0.8 us.
// - After DMA the offset and counts update, pending flag sets, space frees.
// - Address flag sets on filter pass; block flag at 128 bytes clears it.
// - Pending flag follows a non-zero frame count, not cleared by event reads.
`timescale 1ns/1ps
`default_nettype none

module rfb_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   logic [AW:0] next_wptr;
   logic [AW:0] next_rptr;
   logic push;
   logic pop;

   assign in_ready = !((wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]));
   assign out_valid = (wptr != rptr);
   assign out_data = mem[rptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr <= '0;
         rptr <= '0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wptr[AW-1:0]] <= in_data;
      end
   end
endmodule

module rfb_frame_buffer #(
   parameter int BURST_HIGH_CYC = rfb_pkg::BURST_HIGH_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire rfb_pkg::rfb_rx_s rx,
   input wire rfb_pkg::rfb_host_s host,
   output logic [15:0] host_rdata,
   input wire logic rx_event_read,
   input wire logic buf_event_read,
   input wire logic next_frame_seen,
   input wire logic skip_cmd,
   input wire logic keep_fcs_enable,
   input wire logic good_frame_irq_enable,
   input wire logic dma_exclusive_enable,
   input wire logic auto_switch_enable,
   input wire logic burst_limit_enable,
   input wire logic ring_size_select,
   output logic [2:0] dma_request_line,
   input wire logic [2:0] dma_acknowledge_line_n,
   output logic [15:0] dma_data,
   output logic good_frame_event,
   output logic dest_addr_early_flag,
   output logic first_block_early_flag,
   output logic dest_addr_early_irq,
   output logic first_block_early_irq,
   output logic frames_pending_flag,
   output logic frame_committed
);
   logic [15:0] ram [2**rfb_pkg::RAM_AW];
   rfb_pkg::rfb_state_s q;
   rfb_pkg::rfb_state_s n;
   logic mem_we;
   logic [9:0] mem_wa;
   logic [15:0] mem_wd;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [15:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic req;
   logic dma_mode;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // Auto-switch is not built here; exclusive DMA decides alone
   // exclusive wins
   assign dma_mode = dma_exclusive_enable || (dma_exclusive_enable && auto_switch_enable);

   assign req = fifo_out_valid && !q.in_gap;
   assign fifo_out_ready = req && (q.chan <= rfb_pkg::CHAN_MAX) && !dma_acknowledge_line_n[q.chan];

   always_comb begin
      dma_request_line = 3'b000;
      if (req && q.chan <= rfb_pkg::CHAN_MAX) begin
         dma_request_line[q.chan] = 1'b1;
      end
   end

   always_comb begin
      logic release_frame;
      logic complete;
      logic store;
      logic [9:0] rd_next;
      logic [9:0] nwords;
      logic [15:0] ring_mask;
      release_frame = 1'b0;
      complete = 1'b0;
      store = 1'b0;
      rd_next = q.rd_ptr + 10'd1;
      nwords = q.length[10:1] + {9'd0, q.length[0]};
      ring_mask = ring_size_select ? rfb_pkg::RING64_MASK : rfb_pkg::RING16_MASK;
      n = q;
      n.good_evt = 1'b0;
      n.dest_irq = 1'b0;
      n.blk_irq = 1'b0;
      mem_we = 1'b0;
      mem_wa = q.wr_cnt[10:1];
      mem_wd = {8'h00, rx.data};
      fifo_in_valid = 1'b0;
      fifo_in_data = q.status;

      // Early flags are cleared by a buffer event read; a set in the same cycle wins below
      if (buf_event_read) begin
         if (q.st == rfb_pkg::BS_FILL && (q.dest_flag || q.blk_flag)) begin
            n.commit = 1'b1;
         end
         n.dest_flag = 1'b0;
         n.blk_flag = 1'b0;
      end

      case (q.st)
         rfb_pkg::BS_EMPTY: begin
            if (rx.sof) begin
               n.st = rfb_pkg::BS_FILL;
               n.wr_cnt = '0;
               n.rd_ptr = '0;
               n.io_phase = 2'd0;
               n.partial = 1'b0;
               n.commit = 1'b0;
               n.dest_flag = 1'b0;
               n.blk_flag = 1'b0;
            end
         end
         rfb_pkg::BS_FILL: begin
            store = rx.valid && (!rx.fcs || keep_fcs_enable) && (q.wr_cnt < rfb_pkg::MAX_STORE);
            if (store) begin
               mem_we = 1'b1;
               if (q.wr_cnt[0]) begin
                  mem_wd = {rx.data, q.lo_byte};
               end
               n.lo_byte = rx.data;
               n.wr_cnt = q.wr_cnt + 11'd1;
            end
            if (rx.da_pass && !q.blk_flag) begin
               n.dest_flag = 1'b1;
               n.dest_irq = !q.commit;
            end
            if (store && q.wr_cnt == rfb_pkg::FIRST_BLOCK - 11'd1) begin
               n.blk_flag = 1'b1;
               n.dest_flag = 1'b0;
               n.blk_irq = !q.commit;
            end
            if (rx.eof) begin
               n.dest_flag = 1'b0;
               n.blk_flag = 1'b0;
               n.status = rx.status;
               n.length = {5'd0, q.wr_cnt};
               if (rx.accept) begin
                  n.good_evt = rx.good && good_frame_irq_enable;
                  n.st = dma_mode ? rfb_pkg::BS_DMA : rfb_pkg::BS_HELD;
                  n.dma_phase = 2'd0;
                  n.dptr = '0;
               end else begin
                  n.st = rfb_pkg::BS_EMPTY;
               end
            end
         end
         rfb_pkg::BS_HELD: begin
            if (rx_event_read) begin
               n.commit = 1'b1;
            end
         end
         rfb_pkg::BS_DMA: begin
            fifo_in_valid = 1'b1;
            case (q.dma_phase)
               2'd0: fifo_in_data = q.status;
               2'd1: fifo_in_data = q.length;
               default: fifo_in_data = ram[q.dptr];
            endcase
            if (fifo_in_ready) begin
               if (q.dma_phase != 2'd2) begin
                  n.dma_phase = q.dma_phase + 2'd1;
                  if (q.dma_phase == 2'd1 && nwords == 10'd0) begin
                     n.st = rfb_pkg::BS_DRAIN;
                  end
               end else if (q.dptr == nwords - 10'd1) begin
                  n.st = rfb_pkg::BS_DRAIN;
               end else begin
                  n.dptr = q.dptr + 10'd1;
               end
            end
         end
         rfb_pkg::BS_DRAIN: begin
            if (!fifo_out_valid) begin
               complete = 1'b1;
               n.st = rfb_pkg::BS_EMPTY;
            end
         end
         default: n.st = rfb_pkg::BS_EMPTY;
      endcase

      // Host reads of the visible frame and of the DMA registers
      n.rdata = 16'h0000;
      if (host.rd) begin
         if (hit(host.addr, rfb_pkg::OFS_STAT)) begin
            n.rdata = q.status;
         end else if (hit(host.addr, rfb_pkg::OFS_LEN)) begin
            n.rdata = q.length;
         end else if (hit(host.addr, rfb_pkg::OFS_CHAN)) begin
            n.rdata = {14'd0, q.chan};
         end else if (hit(host.addr, rfb_pkg::OFS_SOF)) begin
            n.rdata = q.sof;
         end else if (hit(host.addr, rfb_pkg::OFS_FCNT)) begin
            n.rdata = {4'h0, q.frame_cnt};
         end else if (hit(host.addr, rfb_pkg::OFS_BCNT)) begin
            n.rdata = q.byte_cnt;
         end
      end
      if ((host.rd && hit(host.addr, rfb_pkg::OFS_DATA)) || host.io_rd) begin
         if (host.io_rd && q.io_phase == 2'd0) begin
            n.rdata = q.status;
            n.io_phase = 2'd1;
         end else if (host.io_rd && q.io_phase == 2'd1) begin
            n.rdata = q.length;
            n.io_phase = 2'd2;
         end else if (q.st == rfb_pkg::BS_HELD || (q.st == rfb_pkg::BS_FILL && q.commit)) begin
            n.rdata = ram[q.rd_ptr];
            n.rd_ptr = rd_next;
            n.partial = 1'b1;
            if (q.st == rfb_pkg::BS_HELD && {5'd0, rd_next, 1'b0} >= q.length) begin
               release_frame = 1'b1;
            end
         end
      end

      if (skip_cmd && (q.st == rfb_pkg::BS_FILL || q.st == rfb_pkg::BS_HELD)) begin
         release_frame = 1'b1;
      end
      if (rx_event_read && q.partial && next_frame_seen && q.st == rfb_pkg::BS_HELD) begin
         release_frame = 1'b1;
      end
      if (release_frame) begin
         n.st = rfb_pkg::BS_EMPTY;
         n.commit = 1'b0;
         n.partial = 1'b0;
         n.dest_flag = 1'b0;
         n.blk_flag = 1'b0;
      end
      if (n.st == rfb_pkg::BS_EMPTY) begin
         n.commit = 1'b0;
      end

      // only 0, 1 or 2 stored
      if (host.wr && hit(host.addr, rfb_pkg::OFS_CHAN) && host.wdata[15:0] <= {14'd0, rfb_pkg::CHAN_MAX}) begin
         n.chan = host.wdata[1:0];
      end

      // read restarts counts; a completing frame in the same cycle still counts
      if (host.rd && hit(host.addr, rfb_pkg::OFS_FCNT)) begin
         n.frame_cnt = '0;
      end
      if (host.rd && hit(host.addr, rfb_pkg::OFS_BCNT)) begin
         n.byte_cnt = '0;
      end
      if (complete) begin
         n.frame_cnt = n.frame_cnt + 12'd1;
         n.byte_cnt = n.byte_cnt + q.length + rfb_pkg::HDR_BYTES;
         n.sof = q.ring_ptr;
         n.ring_ptr = (q.ring_ptr + ((q.length + rfb_pkg::ALIGN_ADD) & rfb_pkg::DWORD_MASK)) & ring_mask;
      end

      if (q.in_gap) begin
         n.gap_cnt = q.gap_cnt + 8'd1;
         if (q.gap_cnt == 8'(rfb_pkg::BURST_GAP_CYC - 1)) begin
            n.in_gap = 1'b0;
            n.burst_cnt = '0;
         end
      end else if (req && burst_limit_enable) begin
         n.burst_cnt = q.burst_cnt + 13'd1;
         if (q.burst_cnt == 13'(BURST_HIGH_CYC - 1)) begin
            n.in_gap = 1'b1;
            n.gap_cnt = '0;
         end
      end else if (!req) begin
         n.burst_cnt = '0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         ram[mem_wa] <= mem_wd;
      end
   end

   rfb_fifo #(
      .W(rfb_pkg::WORD_W),
      .D(rfb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(dma_data)
   );

   assign host_rdata = q.rdata;
   assign good_frame_event = q.good_evt;
   assign dest_addr_early_flag = q.dest_flag;
   assign first_block_early_flag = q.blk_flag;
   assign dest_addr_early_irq = q.dest_irq;
   assign first_block_early_irq = q.blk_irq;
   assign frames_pending_flag = (q.frame_cnt != 12'd0);
   assign frame_committed = q.commit;
endmodule

`default_nettype wire

// File: rfb_frame_buffer_sva.sv
// Port-level assertions for the receive frame buffer top module.
// Bound to every rfb_frame_buffer instance; uses only its ports.
`timescale 1ns/1ps
`default_nettype none
module rfb_frame_buffer_chk #(
   parameter int BURST_HIGH_CYC = rfb_pkg::BURST_HIGH_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire rfb_pkg::rfb_rx_s rx,
   input wire rfb_pkg::rfb_host_s host,
   input wire logic [15:0] host_rdata,
   input wire logic rx_event_read,
   input wire logic buf_event_read,
   input wire logic good_frame_irq_enable,
   input wire logic burst_limit_enable,
   input wire logic [2:0] dma_request_line,
   input wire logic good_frame_event,
   input wire logic dest_addr_early_flag,
   input wire logic first_block_early_flag,
   input wire logic dest_addr_early_irq,
   input wire logic first_block_early_irq,
   input wire logic frames_pending_flag,
   input wire logic frame_committed
);
   logic [15:0] hi_cnt;
   // Run length of the request; a burst longer than the limit shows here
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_cnt <= 16'h0000;
      end else if (|dma_request_line) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end else begin
         hi_cnt <= 16'h0000;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_one_chan;
      $onehot0(dma_request_line);
   endproperty
   a_one_chan: assert property (p_one_chan)
      else $error("more than one request line high");
   property p_good_evt;
      good_frame_event |-> $past(rx.eof && rx.accept && rx.good && good_frame_irq_enable) ##1 !good_frame_event;
   endproperty
   a_good_evt: assert property (p_good_evt)
      else $error("good frame event without finished frame");
   property p_quiet;
      frame_committed && $past(frame_committed) |-> !dest_addr_early_irq && !first_block_early_irq;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("early interrupt while frame committed");
   property p_blk_clears;
      $rose(first_block_early_flag) |-> !dest_addr_early_flag;
   endproperty
   a_blk_clears: assert property (p_blk_clears)
      else $error("address flag kept after block flag");
   property p_rd_idle;
      !$past(host.rd || host.io_rd) |-> host_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data without a read");
   property p_pend_fall;
      $fell(frames_pending_flag) |-> $past(host.rd && host.addr == rfb_pkg::OFS_FCNT);
   endproperty
   a_pend_fall: assert property (p_pend_fall)
      else $error("pending flag fell without count read");
   property p_commit_cause;
      $rose(frame_committed) |-> $past(rx_event_read || buf_event_read);
   endproperty
   a_commit_cause: assert property (p_commit_cause)
      else $error("commit without event read");
   property p_burst;
      burst_limit_enable |-> hi_cnt <= BURST_HIGH_CYC;
   endproperty
   a_burst: assert property (p_burst)
      else $error("request burst too long");
endmodule
bind rfb_frame_buffer rfb_frame_buffer_chk #(.BURST_HIGH_CYC(BURST_HIGH_CYC)) chk (.sys_clk, .rst_n, .rx, .host,
   .host_rdata, .rx_event_read, .buf_event_read, .good_frame_irq_enable, .burst_limit_enable, .dma_request_line,
   .good_frame_event, .dest_addr_early_flag, .first_block_early_flag, .dest_addr_early_irq,
   .first_block_early_irq, .frames_pending_flag, .frame_committed);
`default_nettype wire

// File: rfb_dma_host_model.sv
// Behavioural host DMA controller for the receive channel.
// Answers only the chosen channel; slow mode acks every other cycle.
`timescale 1ns/1ps
`default_nettype none
module rfb_dma_host_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] chan,
   input wire logic slow,
   input wire logic [2:0] dma_request_line,
   input wire logic [15:0] dma_data,
   output logic [2:0] dma_acknowledge_line_n
);
   logic [15:0] got[$];
   logic pace;
   // ack answers request, words kept in order
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_acknowledge_line_n <= 3'h7;
         pace <= 1'h0;
      end else begin
         pace <= ~pace;
         if (dma_request_line[chan] && !dma_acknowledge_line_n[chan]) begin
            got.push_back(dma_data);
         end
         dma_acknowledge_line_n <= 3'h7;
         if (dma_request_line[chan] && (!slow || pace)) begin
            dma_acknowledge_line_n[chan] <= 1'h0;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the receive frame buffer and its DMA path.
// Assumes the DMA controller model serves channel 1.
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {int n; bit keep; int src; bit irq; int len;} rfb_row_s;
   // Overlong frame keeps 1518 bytes; CRC kept only when enabled
   rfb_row_s rows[3] = '{'{64, 1, 0, 1, 64}, '{1524, 0, 0, 1, 1518}, '{14, 0, 1, 0, 10}};
   logic sys_clk = 1'h0, rst_n = 1'h0, slow = 1'h0;
   rfb_pkg::rfb_rx_s rx = '0, rda = '0;
   rfb_pkg::rfb_host_s host = '0;
   logic rx_event_read = 1'h0, buf_event_read = 1'h0, next_frame_seen = 1'h0, skip_cmd = 1'h0;
   logic keep_fcs_enable = 1'h0, good_frame_irq_enable = 1'h0, dma_exclusive_enable = 1'h0;
   logic burst_limit_enable = 1'h0, auto_switch_enable = 1'h0, dest_addr_early_irq;
   logic [1:0] chan = 2'h1;
   logic [2:0] dma_request_line, dma_acknowledge_line_n;
   logic [15:0] host_rdata, dma_data, rd;
   logic good_frame_event, dest_addr_early_flag, first_block_early_flag, frames_pending_flag, frame_committed;
   int n_errors = 0, comparisons = 0, dix = 0;
   rfb_frame_buffer #(.BURST_HIGH_CYC(20)) uut (.sys_clk, .rst_n, .rx, .host, .host_rdata, .rx_event_read,
      .buf_event_read, .next_frame_seen, .skip_cmd, .keep_fcs_enable, .good_frame_irq_enable,
      .dma_exclusive_enable, .auto_switch_enable, .burst_limit_enable, .ring_size_select(1'h0),
      .dma_request_line, .dma_acknowledge_line_n, .dma_data, .good_frame_event, .dest_addr_early_flag,
      .first_block_early_flag, .dest_addr_early_irq, .first_block_early_irq(), .frames_pending_flag,
      .frame_committed);
   rfb_dma_host_model dmac (.sys_clk, .rst_n, .chan, .slow, .dma_request_line, .dma_data,
      .dma_acknowledge_line_n);
   always #2.5 sys_clk = ~sys_clk;
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] bv(int i);
      return i[7:0] + 8'h3C;
   endfunction
   // One host cycle; read data is sampled the cycle after the request
   task automatic acc(bit io, bit wr, logic [11:0] a, logic [15:0] wd);
      @(posedge sys_clk);
      host <= '{rd: !wr && !io, wr: wr, io_rd: io, addr: a, wdata: wd};
      @(posedge sys_clk);
      host <= '0;
      #1 rd = host_rdata;
   endtask
   task automatic rreg(logic [11:0] a, logic [15:0] e, string nm);
      acc(0, 0, a, 16'h0000);
      chk(nm, rd, e);
   endtask
   task automatic put(rfb_pkg::rfb_rx_s r);
      @(posedge sys_clk);
      rx <= r;
   endtask
   task automatic ev(logic [2:0] v, logic nf);
      @(posedge sys_clk);
      {skip_cmd, buf_event_read, rx_event_read} <= v;
      next_frame_seen <= nf;
      @(posedge sys_clk);
      {skip_cmd, buf_event_read, rx_event_read} <= 3'h0;
      next_frame_seen <= 1'h0;
      #1;
   endtask
   task automatic fin(logic [15:0] st);
      rfb_pkg::rfb_rx_s r;
      r = '0;
      r.eof = 1'h1;
      r.accept = 1'h1;
      r.good = 1'h1;
      r.status = st;
      put(r);
      put('0);
   endtask
   // Last four bytes of every frame are its CRC; open leaves the frame unfinished
   task automatic frame(int n, bit open, logic [15:0] st);
      rfb_pkg::rfb_rx_s r;
      r = '0;
      r.sof = 1'h1;
      put(r);
      for (int i = 0; i < n; i++) begin
         r = '0;
         r.valid = 1'h1;
         r.data = bv(i);
         r.da_pass = (i == 6);
         r.fcs = (i >= n - 4);
         put(r);
      end
      if (open) put('0);
      else fin(st);
   endtask
   // Source 0 memory reads, 1 I/O port reads, 2 words taken by DMA
   task automatic take(int src, logic [11:0] a);
      if (src < 2) begin
         acc(src[0], 0, a, 16'h0000);
      end else begin
         rd = dmac.got[dix];
         dix++;
      end
   endtask
   task automatic readout(int src, int len, logic [15:0] st);
      take(src, rfb_pkg::OFS_STAT);
      chk("status", rd, st);
      take(src, rfb_pkg::OFS_LEN);
      chk("length", rd, 16'(len));
      for (int k = 0; 2 * k < len; k++) begin
         take(src, rfb_pkg::OFS_DATA);
         chk("data", rd, {bv(2 * k + 1), bv(2 * k)});
      end
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'h1;
      rreg(rfb_pkg::OFS_FCNT, 16'h0000, "frame count");
      rreg(rfb_pkg::OFS_BCNT, 16'h0000, "byte count");
      rreg(rfb_pkg::OFS_SOF, 16'h0000, "frame start");
      acc(0, 1, rfb_pkg::OFS_CHAN, 16'h0003);
      rreg(rfb_pkg::OFS_CHAN, 16'h0000, "channel");
      acc(0, 1, rfb_pkg::OFS_CHAN, 16'h0001);
      rreg(rfb_pkg::OFS_CHAN, 16'h0001, "channel");
      foreach (rows[i]) begin
         keep_fcs_enable <= rows[i].keep;
         good_frame_irq_enable <= rows[i].irq;
         frame(rows[i].n, 0, 16'h0100 + 16'(i));
         #1 chk("good event", 16'(good_frame_event), 16'(rows[i].irq));
         ev(3'h1, 1'h0);
         chk("commit", 16'(frame_committed), 16'h0001);
         readout(rows[i].src, rows[i].len, 16'h0100 + 16'(i));
         @(posedge sys_clk);
         #1 chk("release", 16'(frame_committed), 16'h0000);
      end
      chk("dma idle", 16'(dmac.got.size()), 16'h0000);
      keep_fcs_enable <= 1'h0;
      frame(134, 1, 16'h0000);
      #1 chk("early flags", 16'({first_block_early_flag, dest_addr_early_flag}), 16'h0002);
      ev(3'h2, 1'h0);
      chk("commit early", 16'(frame_committed), 16'h0001);
      // A late address pass may raise the flag but not its interrupt
      rda.da_pass = 1'h1;
      put(rda);
      put('0);
      #1 chk("early irq held", 16'({dest_addr_early_irq, dest_addr_early_flag}), 16'h0001);
      fin(16'h0200);
      rreg(rfb_pkg::OFS_DATA, {bv(1), bv(0)}, "data");
      ev(3'h4, 1'h0);
      chk("skip", 16'(frame_committed), 16'h0000);
      rreg(rfb_pkg::OFS_DATA, 16'h0000, "data empty");
      frame(24, 0, 16'h0300);
      ev(3'h1, 1'h0);
      acc(0, 0, rfb_pkg::OFS_DATA, 16'h0000);
      frame(30, 0, 16'h0301);
      rreg(rfb_pkg::OFS_LEN, 16'h0014, "held length");
      ev(3'h1, 1'h1);
      chk("implied skip", 16'(frame_committed), 16'h0000);
      dma_exclusive_enable <= 1'h1;
      // Both set: the exclusive bit must still send every frame by DMA
      auto_switch_enable <= 1'h1;
      keep_fcs_enable <= 1'h1;
      frame(14, 0, 16'h0400);
      for (int t = 0; t < 3000 && dmac.got.size() < 9; t++) @(posedge sys_clk);
      slow <= 1'h1;
      burst_limit_enable <= 1'h1;
      frame(60, 0, 16'h0500);
      for (int t = 0; t < 3000 && dmac.got.size() < 41; t++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      #1 chk("dma words", 16'(dmac.got.size()), 16'h0029);
      readout(2, 14, 16'h0400);
      readout(2, 60, 16'h0500);
      chk("pending", 16'(frames_pending_flag), 16'h0001);
      ev(3'h2, 1'h0);
      chk("pending kept", 16'(frames_pending_flag), 16'h0001);
      rreg(rfb_pkg::OFS_SOF, 16'h0014, "frame start");
      rreg(rfb_pkg::OFS_FCNT, 16'h0002, "frame count");
      rreg(rfb_pkg::OFS_BCNT, 16'h0052, "byte count");
      rreg(rfb_pkg::OFS_FCNT, 16'h0000, "frame count");
      chk("pending clear", 16'(frames_pending_flag), 16'h0000);
      conclude();
   end
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end
endmodule
`default_nettype wire
